// file: include/cic_pkg.sv
// Functional notes
// RQ1: ch1 direction 00 output, 01 first line, 10 second line, 11 internal trigger.
// RQ2: ch2 direction 01 takes second line, 10 takes first line.
// RQ3: ch3/ch4 paired alike: 01 own line, 10 partner line.
// RQ4: software picks code 11 only when trigger source selects an internal trigger.
// RQ5: direction field writable only while the channel enable bit is 0.
// RQ6: filter validates a new level after N consecutive samples at that level.
// RQ7: filter code 0000 means no filtering, sampling at the dead-time rate.
// RQ8: codes 0001..0011 sample at timer clock with N of 2, 4, 8.
// RQ9: codes 0100..1001 sample at dead-time /2, /4, /8 with N 6 then 8.
// RQ10: codes 1010..1100 use /16, 1101..1111 use /32, N 5, 6, 8.
// RQ11: prescaler 00 captures every edge, 01/10/11 every 2nd, 4th, 8th.
// RQ12: prescaler event count is cleared while channel enable is 0.
// RQ13: output channel polarity 0 active high, 1 active low.
// RQ14: software keeps secondary polarity cleared on output channels.
// RQ15: input pair 00 means rising edges, non-inverted level.
// RQ16: input pair 01 means falling edges, inverted level.
// RQ17: software never programs reserved input polarity pair 10.
// RQ18: pair 11 means both edges, non-inverted level, not for encoder use.
// RQ19: enable/polarity register holds four 4-bit groups: en, pol, res, npol.
// RQ20: input channel enable 1 permits captures, 0 inhibits them.
// RQ21: output enable 0 drives low with oe off; 1 drives ref with polarity.
// RQ22: capture register holds last captured counter value, ignores writes.
// RQ23: filter sample count restarts when a sample differs from candidate level.
// RQ24: prescaler counts only polarity-matching edges, captures at the ratio.
`default_nettype none
package cic_pkg;
    localparam int NUM_CH = 4;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_MODE12 = 8'h18;
    localparam logic [7:0] OFS_MODE34 = 8'h1C;
    localparam logic [7:0] OFS_ENPOL = 8'h20;
    localparam logic [7:0] OFS_CAP_BASE = 8'h34;
    localparam logic [7:0] OFS_CAP_STRIDE = 8'h04;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] ENPOL_RST = 16'h0000;
    localparam logic [15:0] ENPOL_RW_MASK = 16'hBBBB;
    localparam int SEL_LSB = 0;
    localparam int PSC_LSB = 2;
    localparam int FLT_LSB = 4;
    localparam int MODE_STRIDE = 8;
    localparam int EN_BIT = 0;
    localparam int POL_BIT = 1;
    localparam int NPOL_BIT = 3;
    localparam int ENPOL_STRIDE = 4;
    localparam logic [1:0] DIR_OUTPUT = 2'h0;
    localparam logic [1:0] DIR_OWN = 2'h1;
    localparam logic [1:0] DIR_PARTNER = 2'h2;
    localparam logic [1:0] DIR_TRIG = 2'h3;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam int DTS_DIV_RST = 1;

    // 0 timer clock, 1 dead-time rate, 2..6 dead-time /2../32
    function automatic logic [2:0] cic_rate_sel(input logic [3:0] code);
        case (code)
            4'h0: return 3'h1; // RQ7
            4'h1, 4'h2, 4'h3: return 3'h0; // RQ8
            4'h4, 4'h5: return 3'h2; // RQ9
            4'h6, 4'h7: return 3'h3;
            4'h8, 4'h9: return 3'h4;
            4'hA, 4'hB, 4'hC: return 3'h5; // RQ10
            default: return 3'h6;
        endcase
    endfunction : cic_rate_sel

    function automatic logic [3:0] cic_need_n(input logic [3:0] code);
        case (code)
            4'h0: return 4'h1; // RQ7
            4'h1: return 4'h2; // RQ8
            4'h2: return 4'h4;
            4'h4, 4'h6, 4'h8, 4'hB, 4'hE: return 4'h6; // RQ9
            4'hA, 4'hD: return 4'h5; // RQ10
            default: return 4'h8;
        endcase
    endfunction : cic_need_n
endpackage : cic_pkg
`default_nettype wire

// file: logic/cic_filter.sv
`timescale 1ns/1ps
`default_nettype none
module cic_filter
    import cic_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sample_en,
    input wire logic raw,
    input wire logic [3:0] need_n,
    output logic level_reg
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_inc;
    logic done;

    assign cnt_inc = cnt_reg + 4'h1;
    assign done = cnt_inc >= need_n;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 4'h0;
        end else if (sample_en) begin
            if (raw == level_reg || done) begin
                cnt_reg <= 4'h0; // RQ23
            end else begin
                cnt_reg <= cnt_inc; // RQ6
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            level_reg <= 1'b0;
        end else if (sample_en && raw != level_reg && done) begin
            level_reg <= raw; // RQ6
        end
    end

    property p_flt_valid;
        @(posedge mclk) disable iff (!rst_b)
        $changed(level_reg) |-> $past(sample_en) && ($past(cnt_reg) + 4'h1 >= $past(need_n));
    endproperty
    a_flt_valid: assert property (p_flt_valid) else $error("filter moved early"); // RQ6
    property p_flt_restart;
        @(posedge mclk) disable iff (!rst_b)
        sample_en && raw == level_reg |=> cnt_reg == 4'h0;
    endproperty
    a_flt_restart: assert property (p_flt_restart) else $error("count kept"); // RQ23
endmodule : cic_filter
`default_nettype wire

// file: logic/cic_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module cic_prescaler
    import cic_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic edge_in,
    input wire logic [1:0] ratio,
    output logic capture_reg
);
    logic [2:0] cnt_reg;
    logic [2:0] last;

    always_comb begin
        case (ratio)
            2'h0: last = 3'h0; // RQ11
            2'h1: last = 3'h1;
            2'h2: last = 3'h3;
            default: last = 3'h7;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 3'h0;
            capture_reg <= 1'b0;
        end else if (!enable) begin
            cnt_reg <= 3'h0; // RQ12
            capture_reg <= 1'b0;
        end else if (edge_in) begin
            cnt_reg <= (cnt_reg >= last) ? 3'h0 : cnt_reg + 3'h1; // RQ24
            capture_reg <= cnt_reg >= last;
        end else begin
            capture_reg <= 1'b0;
        end
    end

    property p_psc_clear;
        @(posedge mclk) disable iff (!rst_b)
        !enable |=> cnt_reg == 3'h0 && !capture_reg;
    endproperty
    a_psc_clear: assert property (p_psc_clear) else $error("count not cleared"); // RQ12
    property p_psc_fire;
        @(posedge mclk) disable iff (!rst_b)
        capture_reg |-> $past(enable && edge_in && cnt_reg >= last);
    endproperty
    a_psc_fire: assert property (p_psc_fire) else $error("capture off ratio"); // RQ11
endmodule : cic_prescaler
`default_nettype wire

// file: logic/cic_top.sv
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cic_top
    import cic_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 16,
    parameter int DTS_DIV = DTS_DIV_RST
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NUM_CH-1:0] input_line,
    input wire logic internal_trigger_input,
    input wire logic trigger_source_internal,
    input wire logic [CNT_W-1:0] counter_value,
    input wire logic [NUM_CH-1:0] compare_ref,
    output logic [NUM_CH-1:0] compare_output_signal,
    output logic [NUM_CH-1:0] compare_output_en,
    output logic [NUM_CH-1:0] filtered_edge_signal,
    output logic [NUM_CH-1:0] edge_event,
    output logic [NUM_CH-1:0] capture_event
);
    logic [15:0] mode12_reg;
    logic [15:0] mode34_reg;
    logic [15:0] ccer_reg;
    logic [31:0] mode_all;
    logic [NUM_CH-1:0][CNT_W-1:0] cap_reg;
    logic [NUM_CH-1:0] sync1_reg;
    logic [NUM_CH-1:0] sync2_reg;
    logic [NUM_CH-1:0] filt;
    logic [NUM_CH-1:0] src;
    logic [NUM_CH-1:0] src_reg;
    logic [NUM_CH-1:0] edge_q;
    logic [NUM_CH-1:0] cap_pulse;
    logic [7:0] dts_cnt_reg;
    logic [4:0] div_cnt_reg;
    logic dts_tick;
    logic [6:0] rate_tick;
    logic addr_go;
    logic wr_pend_reg;
    logic rd_pend_reg;
    logic rd_wait_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [7:0] addr_lo;
    logic [31:0] rd_mux;
    logic trig_ok;

    assign mode_all = {mode34_reg, mode12_reg};
    assign addr_lo = addr_reg[7:0];

    // bus: writes zero-wait, reads take one wait state so a read right
    // after a write always sees the new value
    assign addr_go = hsel && hready && htrans == HTRANS_NONSEQ;
    assign hreadyout = !(rd_pend_reg && !rd_wait_reg);
    assign hresp = 1'b0;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= '0;
        end else if (hready) begin
            wr_pend_reg <= addr_go && hwrite && hsize == HSIZE_WORD;
            rd_pend_reg <= addr_go && !hwrite;
            if (addr_go) begin
                addr_reg <= haddr;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rd_wait_reg <= 1'b0;
            hrdata <= 32'h00000000;
        end else begin
            rd_wait_reg <= rd_pend_reg && !rd_wait_reg;
            if (rd_pend_reg && !rd_wait_reg) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h00000000;
        case (addr_lo)
            OFS_STATUS: rd_mux = {24'h000000, src_reg, filt};
            OFS_MODE12: rd_mux = {16'h0000, mode12_reg};
            OFS_MODE34: rd_mux = {16'h0000, mode34_reg};
            OFS_ENPOL: rd_mux = {16'h0000, ccer_reg};
            default: begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (addr_lo == OFS_CAP_BASE + 8'(i) * OFS_CAP_STRIDE) begin
                        rd_mux = 32'(cap_reg[i]);
                    end
                end
            end
        endcase
    end

    // direction bits of a live channel are kept
    function automatic logic [15:0] lock_sel(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic en_lo,
                                             input logic en_hi);
        logic [15:0] r;
        r = new_v;
        if (en_lo) begin
            r[SEL_LSB +: 2] = old_v[SEL_LSB +: 2];
        end
        if (en_hi) begin
            r[MODE_STRIDE + SEL_LSB +: 2] = old_v[MODE_STRIDE + SEL_LSB +: 2];
        end
        return r;
    endfunction : lock_sel

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            mode12_reg <= MODE_RST;
            mode34_reg <= MODE_RST;
        end else if (wr_pend_reg) begin
            if (addr_lo == OFS_MODE12) begin
                mode12_reg <= lock_sel(mode12_reg, hwdata[15:0],
                    ccer_reg[EN_BIT], ccer_reg[ENPOL_STRIDE + EN_BIT]); // RQ5
            end
            if (addr_lo == OFS_MODE34) begin
                mode34_reg <= lock_sel(mode34_reg, hwdata[15:0],
                    ccer_reg[2 * ENPOL_STRIDE + EN_BIT],
                    ccer_reg[3 * ENPOL_STRIDE + EN_BIT]); // RQ5
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ccer_reg <= ENPOL_RST;
        end else if (wr_pend_reg && addr_lo == OFS_ENPOL) begin
            ccer_reg <= hwdata[15:0] & ENPOL_RW_MASK; // RQ19
        end
    end

    // pins are asynchronous to mclk
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= input_line;
            sync2_reg <= sync1_reg;
        end
    end

    // dead-time sampling rate and its binary submultiples
    assign dts_tick = dts_cnt_reg == 8'(DTS_DIV - 1);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dts_cnt_reg <= 8'h00;
            div_cnt_reg <= 5'h00;
        end else begin
            dts_cnt_reg <= dts_tick ? 8'h00 : dts_cnt_reg + 8'h01;
            if (dts_tick) begin
                div_cnt_reg <= div_cnt_reg + 5'h01;
            end
        end
    end

    assign rate_tick[0] = 1'b1;
    assign rate_tick[1] = dts_tick;
    for (genvar k = 2; k < 7; k++) begin : g_rate
        assign rate_tick[k] = dts_tick && (&div_cnt_reg[k-2:0]); // RQ9
    end

    // trigger-sourced mode only works with an internal trigger selected
    assign trig_ok = internal_trigger_input && trigger_source_internal; // RQ4

    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        localparam int P = c ^ 1;
        logic [1:0] sel;
        logic [1:0] psc;
        logic [3:0] flt;
        logic en;
        logic pol;
        logic npol;
        logic rise;
        logic fall;

        assign sel = mode_all[c * MODE_STRIDE + SEL_LSB +: 2];
        assign psc = mode_all[c * MODE_STRIDE + PSC_LSB +: 2];
        assign flt = mode_all[c * MODE_STRIDE + FLT_LSB +: 4];
        assign en = ccer_reg[c * ENPOL_STRIDE + EN_BIT];
        assign pol = ccer_reg[c * ENPOL_STRIDE + POL_BIT];
        assign npol = ccer_reg[c * ENPOL_STRIDE + NPOL_BIT];

        cic_filter u_filter (
            .mclk(mclk),
            .rst_b(rst_b),
            .sample_en(rate_tick[cic_rate_sel(flt)]),
            .raw(sync2_reg[c]),
            .need_n(cic_need_n(flt)),
            .level_reg(filt[c])
        );

        always_comb begin
            case (sel)
                DIR_OWN: src[c] = filt[c]; // RQ1 RQ2 RQ3
                DIR_PARTNER: src[c] = filt[P]; // RQ1 RQ2 RQ3
                DIR_TRIG: src[c] = trig_ok; // RQ1
                default: src[c] = 1'b0;
            endcase
        end

        // pair 10 is reserved and behaves as rising here
        assign rise = src[c] && !src_reg[c] && !(pol && !npol); // RQ15 RQ18
        assign fall = !src[c] && src_reg[c] && pol; // RQ16 RQ18
        assign edge_q[c] = (sel != DIR_OUTPUT) && (rise || fall);
        assign filtered_edge_signal[c] = src_reg[c] ^ (pol && !npol); // RQ16

        cic_prescaler u_prescaler (
            .mclk(mclk),
            .rst_b(rst_b),
            .enable(en && sel != DIR_OUTPUT),
            .edge_in(edge_q[c]),
            .ratio(psc),
            .capture_reg(cap_pulse[c])
        );

        assign compare_output_en[c] = sel == DIR_OUTPUT && en; // RQ21
        assign compare_output_signal[c] = compare_output_en[c] && (compare_ref[c] ^ pol); // RQ13
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            src_reg <= '0;
            edge_event <= '0;
            capture_event <= '0;
        end else begin
            src_reg <= src;
            edge_event <= edge_q;
            capture_event <= cap_pulse;
        end
    end

    // prescaler already holds off while disabled, so no write port here
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cap_reg <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (cap_pulse[i]) begin
                    cap_reg[i] <= counter_value; // RQ20 RQ22
                end
            end
        end
    end

    property p_dir_locked;
        @(posedge mclk) disable iff (!rst_b)
        ccer_reg[EN_BIT] |=> $stable(mode12_reg[SEL_LSB +: 2]);
    endproperty
    a_dir_locked: assert property (p_dir_locked) else $error("direction changed"); // RQ5
    property p_out_off;
        @(posedge mclk) disable iff (!rst_b)
        g_ch[0].sel == DIR_OUTPUT && !ccer_reg[EN_BIT]
            |-> !compare_output_en[0] && !compare_output_signal[0];
    endproperty
    a_out_off: assert property (p_out_off) else $error("disabled output driven"); // RQ21
    property p_out_pol;
        @(posedge mclk) disable iff (!rst_b)
        g_ch[1].sel == DIR_OUTPUT && g_ch[1].en
            |-> compare_output_en[1] && compare_output_signal[1] == (compare_ref[1] ^ g_ch[1].pol);
    endproperty
    a_out_pol: assert property (p_out_pol) else $error("output polarity wrong"); // RQ13
    property p_cap_load;
        @(posedge mclk) disable iff (!rst_b)
        cap_pulse[0] |=> cap_reg[0] == $past(counter_value) && capture_event[0];
    endproperty
    a_cap_load: assert property (p_cap_load) else $error("capture not loaded"); // RQ22
    property p_cap_inhibit;
        @(posedge mclk) disable iff (!rst_b)
        !ccer_reg[EN_BIT] [*3] |-> $stable(cap_reg[0]);
    endproperty
    a_cap_inhibit: assert property (p_cap_inhibit) else $error("capture while off"); // RQ20
    property p_mux12;
        @(posedge mclk) disable iff (!rst_b)
        (g_ch[1].sel == DIR_OWN |-> src[1] == filt[1])
            and (g_ch[1].sel == DIR_PARTNER |-> src[1] == filt[0]);
    endproperty
    a_mux12: assert property (p_mux12) else $error("ch2 source wrong"); // RQ2
    property p_mux34;
        @(posedge mclk) disable iff (!rst_b)
        g_ch[2].sel == DIR_PARTNER |-> src[2] == filt[3];
    endproperty
    a_mux34: assert property (p_mux34) else $error("ch3 source wrong"); // RQ3
    property p_rise;
        @(posedge mclk) disable iff (!rst_b)
        g_ch[0].sel == DIR_OWN && !g_ch[0].pol && $rose(filt[0]) |=> edge_event[0];
    endproperty
    a_rise: assert property (p_rise) else $error("rising edge missed"); // RQ15
    property p_fall;
        @(posedge mclk) disable iff (!rst_b)
        g_ch[0].sel == DIR_OWN && g_ch[0].pol && !g_ch[0].npol && $rose(filt[0])
            |=> !edge_event[0];
    endproperty
    a_fall: assert property (p_fall) else $error("rising seen on falling"); // RQ16
    property p_rd_wait;
        @(posedge mclk) disable iff (!rst_b)
        addr_go && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");

    c_capture: cover property (@(posedge mclk) disable iff (!rst_b) capture_event[0]);
    c_both: cover property (@(posedge mclk) disable iff (!rst_b)
        g_ch[0].pol && g_ch[0].npol && edge_event[0]);
    c_locked: cover property (@(posedge mclk) disable iff (!rst_b)
        wr_pend_reg && addr_lo == OFS_MODE12 && ccer_reg[EN_BIT]);
endmodule : cic_top
`default_nettype wire

// file: testbench/cic_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module cic_far_side
    import cic_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [NUM_CH-1:0] line_cmd,
    input wire logic trig_cmd,
    input wire logic tsel_cmd,
    output logic [NUM_CH-1:0] input_line,
    output logic internal_trigger_input,
    output logic trigger_source_internal,
    output logic [CNT_W-1:0] counter_value
);
    // raw pins, the block must synchronise them
    assign input_line = line_cmd;
    assign trigger_source_internal = tsel_cmd;
    // no trigger pulse unless an internal source is chosen
    assign internal_trigger_input = trig_cmd & tsel_cmd;
    // odd step keeps stored values distinct
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            counter_value <= '0;
        end else begin
            counter_value <= counter_value + CNT_W'(7);
        end
    end
endmodule : cic_far_side
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cic_pkg::*;
;
    localparam int DTSD = 1;
    logic mclk, rst_b, hsel, hwrite, hready_w, hresp, rd_on, trig, tsel;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] haddr;
    logic [31:0] hwdata, hrdata;
    logic [3:0] lines, cref, line_w, cos, coe, fes, eev, cev;
    logic it_w, tsrc_w, hr_s;
    int n_edge = 0;
    int e0;
    logic [15:0] cnt_w, cnt_d;
    logic [15:0] last_cap [4] = '{16'h0, 16'h0, 16'h0, 16'h0};
    logic [3:0] rm [4] = '{4'h3, 4'h0, 4'h0, 4'hC};
    logic [31:0] rd_q [$];
    logic [3:0] ev_q [$];
    int miscompares = 0;
    int n_checks = 0;

    cic_top #(.DTS_DIV(DTSD)) dut (
        .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready_w),
        .hreadyout(hready_w), .hresp(hresp), .hrdata(hrdata), .input_line(line_w),
        .internal_trigger_input(it_w), .trigger_source_internal(tsrc_w),
        .counter_value(cnt_w), .compare_ref(cref), .compare_output_signal(cos),
        .compare_output_en(coe), .filtered_edge_signal(fes), .edge_event(eev),
        .capture_event(cev)
    );
    cic_far_side far (
        .mclk(mclk), .rst_b(rst_b), .line_cmd(lines), .trig_cmd(trig),
        .tsel_cmd(tsel), .input_line(line_w), .internal_trigger_input(it_w),
        .trigger_source_internal(tsrc_w), .counter_value(cnt_w)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // hready is sampled at the falling edge, settled
    task automatic ap(input logic [7:0] a, input logic w);
        haddr <= a;
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge mclk); while (hr_s !== 1'b1);
        htrans <= 2'h0;
    endtask : ap

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ap(a, 1'b1);
        hwdata <= d;
        do @(posedge mclk); while (hr_s !== 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        ap(a, 1'b0);
        rd_on <= 1'b1;
        do @(posedge mclk); while (hr_s !== 1'b1);
        rd_on <= 1'b0;
    endtask : rd

    task automatic lv(input logic [3:0] v, input logic [3:0] m, input int w);
        lines <= v;
        if (m !== 4'h0) ev_q.push_back(m);
        repeat (w) @(posedge mclk);
    endtask : lv

    function automatic int nf(input int c);
        case (c)
            0: return 1;
            1: return 2;
            2: return 4;
            4, 6, 8, 11, 14: return 6;
            10, 13: return 5;
            default: return 8;
        endcase
    endfunction : nf

    function automatic int df(input int c);
        if (c < 4) return (c == 0) ? DTSD : 1;
        if (c < 10) return DTSD << ((c - 2) / 2);
        return (c < 13) ? DTSD * 16 : DTSD * 32;
    endfunction : df

    always @(negedge mclk) begin
        hr_s = hready_w;
        if (eev[0] === 1'b1) n_edge++;
        if (rd_on && hready_w === 1'b1) begin
            cmp(hrdata, rd_q.size() ? rd_q.pop_front() : 32'hDEAD_BEEF);
        end
        if (cev !== 4'h0) begin
            for (int c = 0; c < 4; c++) begin
                if (cev[c] === 1'b1) last_cap[c] = cnt_d;
            end
            cmp({28'h0, cev}, ev_q.size() ? {28'h0, ev_q.pop_front()} : 32'h0);
        end
        cnt_d = cnt_w;
    end

    initial begin
        repeat (60000) @(posedge mclk);
        miscompares++;
        print_verdict();
    end

    initial begin
        {rst_b, hwrite, rd_on, trig, tsel, lines, cref, haddr, hwdata} = '0;
        {hsel, htrans, hsize} = {1'b1, 2'h0, HSIZE_WORD};
        void'($urandom(32'hFD5F387E));
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(OFS_ENPOL, 32'h0);
        rd(OFS_MODE12, 32'h0);
        rd(OFS_MODE34, 32'h0);
        rd(8'h44, 32'h0);
        rd(OFS_STATUS, 32'h0);
        cmp({31'h0, hresp}, 32'h0);
        wr(OFS_ENPOL, 32'hFFFF);
        rd(OFS_ENPOL, 32'hBBBB);
        // secondary polarity stays clear on output channels
        for (int i = 0; i < 8; i++) begin
            wr(OFS_ENPOL, {18'h0, i[0], i[1], 12'h0});
            cref <= {i[2], 3'($urandom)};
            @(negedge mclk);
            cmp({28'h0, cos}, {28'h0, i[1] & (i[2] ^ i[0]), 3'h0});
            cmp({28'h0, coe}, {28'h0, i[1], 3'h0});
            @(posedge mclk);
        end
        wr(OFS_ENPOL, 32'h0);
        wr(OFS_MODE12, 32'h0201);
        wr(OFS_MODE34, 32'h0102);
        wr(OFS_ENPOL, 32'h1111);
        for (int i = 0; i < 4; i++) begin
            lv(4'h1 << i, rm[i], 12);
            lv(4'h0, 4'h0, 12);
        end
        wr(OFS_MODE12, 32'h0);
        rd(OFS_MODE12, 32'h0201);
        wr(OFS_ENPOL, 32'h1);
        for (int p = 0; p < 4; p++) begin
            wr(OFS_ENPOL, 32'h0);
            wr(OFS_MODE12, 32'h0201 | (p << 2));
            wr(OFS_ENPOL, 32'h1);
            for (int k = 1; k <= 8; k++) begin
                lv(4'h1, (k % (1 << p) == 0) ? 4'h1 : 4'h0, 12);
                lv(4'h0, 4'h0, 12);
            end
        end
        wr(OFS_MODE12, 32'h0209);
        for (int k = 1; k <= 8; k++) begin
            if (k == 4) wr(OFS_ENPOL, 32'h0);
            if (k == 5) wr(OFS_ENPOL, 32'h1);
            lv(4'h1, (k == 8) ? 4'h1 : 4'h0, 12);
            lv(4'h0, 4'h0, 12);
        end
        wr(OFS_MODE12, 32'h0201);
        e0 = n_edge;
        // reserved pair 10 is never programmed
        for (int j = 0; j < 3; j++) begin
            wr(OFS_ENPOL, (j == 0) ? 32'h1 : (j == 1) ? 32'h3 : 32'hB);
            lv(4'h1, {3'h0, j != 1}, 12);
            @(negedge mclk);
            cmp({31'h0, fes[0]}, {31'h0, j != 1});
            @(posedge mclk);
            lv(4'h0, {3'h0, j != 0}, 12);
        end
        cmp(32'(n_edge - e0), 32'h4);
        rd(OFS_CAP_BASE, {16'h0, last_cap[0]});
        wr(OFS_CAP_BASE, 32'h1234);
        rd(OFS_CAP_BASE, {16'h0, last_cap[0]});
        wr(OFS_ENPOL, 32'h0);
        tsel <= 1'b1;
        wr(OFS_MODE12, 32'h0203);
        rd(OFS_MODE12, 32'h0203);
        wr(OFS_ENPOL, 32'h1);
        ev_q.push_back(4'h1);
        trig <= 1'b1;
        repeat (12) @(posedge mclk);
        trig <= 1'b0;
        lv(4'h1, 4'h0, 12);
        lv(4'h0, 4'h0, 12);
        wr(OFS_ENPOL, 32'h0);
        wr(OFS_MODE12, 32'h0201);
        wr(OFS_ENPOL, 32'h1);
        for (int c = 0; c < 16; c++) begin
            int w;
            w = (nf(c) + 1) * df(c) + 8;
            wr(OFS_MODE12, 32'h0201 | (c << 4));
            if (c > 0) lv(4'h1, 4'h0, 1 + int'($urandom % ((nf(c) - 1) * df(c))));
            lv(4'h0, 4'h0, w);
            lv(4'h1, 4'h1, w);
            lv(4'h0, 4'h0, w);
        end
        repeat (20) @(posedge mclk);
        cmp(ev_q.size(), 32'h0);
        cmp(rd_q.size(), 32'h0);
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
